// >>> rtl/ieg_pkg.sv
// Constants and types for the interrupt enable gating block.
// Assumes a single system clock and a synchronous, active-low reset.
package ieg_pkg;

  // ==========================================================
  // Register map (byte addresses on the Avalon-MM slave)
  localparam logic [7:0] OFS_ENABLE_LOW  = 8'ha8;
  localparam logic [7:0] OFS_ENABLE_HIGH = 8'he8;
  localparam logic [7:0] OFS_BIT_ACCESS  = 8'h04;
  localparam logic [7:0] OFS_STATUS      = 8'h08;

  // ==========================================================
  // Reset values and implemented bits
  localparam logic [7:0] LOW_RESET        = 8'h00;
  localparam logic [7:0] HIGH_RESET       = 8'h00;
  localparam logic [7:0] HIGH_IMPL_MASK   = 8'h07;
  localparam logic [7:0] READ_ZERO_BYTE   = 8'h00;
  localparam logic [31:0] READ_ZERO_WORD  = 32'h0000_0000;

  // ==========================================================
  // Field positions of the low enable register
  localparam int GLOBAL_BIT   = 7;
  localparam int COUNTER_BIT  = 6;
  localparam int TIMER2_BIT   = 5;
  localparam int SERIAL_BIT   = 4;
  localparam int TIMER1_BIT   = 3;
  localparam int EXT1_BIT     = 2;
  localparam int TIMER0_BIT   = 1;
  localparam int EXT0_BIT     = 0;
  // Field positions of the high enable register
  localparam int OVERRUN_BIT  = 2;
  localparam int CONVERT_BIT  = 1;
  localparam int CAN_BIT      = 0;

  // ==========================================================
  // Source vector: [6:0] follow the low register, [9:7] the high
  localparam int NUM_SRC      = 10;
  localparam int LOW_SRC      = 7;
  localparam int SRC_OVERRUN  = 9;
  localparam int SRC_CONVERT  = 8;
  localparam int SRC_CAN      = 7;

  // ==========================================================
  // Bit access register fields
  localparam int BITOP_IDX_LSB = 0;
  localparam int BITOP_IDX_MSB = 2;
  localparam int BITOP_VAL_BIT = 3;
  localparam int BITOP_SEL_BIT = 4;
  // Status register fields
  localparam int STAT_REQ_LSB  = 0;
  localparam int STAT_PEND_LSB = 16;

  // ==========================================================
  // Bus carrier and slave states
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } ieg_bus_req_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } ieg_bus_state_t;

endpackage : ieg_pkg

// >>> rtl/ieg_gate.sv
// Per-source AND gating of pending flags with enables.
// Assumes pending flags come from logic on the same clock.
`timescale 1ns/1ps
module ieg_gate (
  input  wire logic                       clock_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       global_en_in,
  input  wire logic [ieg_pkg::NUM_SRC-1:0] source_en_in,
  input  wire logic [ieg_pkg::NUM_SRC-1:0] pending_in,
  output logic      [ieg_pkg::NUM_SRC-1:0] request_out
);

  // ==========================================================
  // Gating
  // Kept combinational so a request follows its flag in-cycle
  genvar g;
  generate
    for (g = 0; g < ieg_pkg::NUM_SRC; g++) begin : g_src
      always_comb begin
        request_out[g] = pending_in[g] & source_en_in[g]
                         & global_en_in;
      end
    end
  endgenerate

  // ==========================================================
  // Checks
  AST_REQ_NEEDS_ALL: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (request_out == (pending_in & source_en_in &
                     {ieg_pkg::NUM_SRC{global_en_in}})))
    else $error("Request without flag and both enables");

  AST_FLAG_DROP: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    $fell(global_en_in) |-> request_out == '0)
    else $error("Request held after global enable fell");

endmodule : ieg_gate

// >>> rtl/ieg_avs.sv
// Avalon-MM slave handshake: one wait cycle per access.
// Assumes the master holds its request until waitrequest is low.
`timescale 1ns/1ps
module ieg_avs (
  input  wire logic                  clock_in,
  input  wire logic                  rst_n_in,
  input  wire ieg_pkg::ieg_bus_req_t bus_in,
  output logic                       waitrequest_out,
  output logic                       accept_out
);

  // ==========================================================
  // Handshake state
  ieg_pkg::ieg_bus_state_t state;
  ieg_pkg::ieg_bus_state_t next_state;
  logic                    active;

  always_comb begin
    active = bus_in.read | bus_in.write;
    case (state)
      ieg_pkg::BUS_IDLE: begin
        next_state = active ? ieg_pkg::BUS_ACK : ieg_pkg::BUS_IDLE;
      end
      ieg_pkg::BUS_ACK: begin
        next_state = ieg_pkg::BUS_IDLE;
      end
      default: begin
        next_state = ieg_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state <= ieg_pkg::BUS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Wait cycle gives read data a flop stage before it is taken
  always_comb begin
    waitrequest_out = active & (state != ieg_pkg::BUS_ACK);
    accept_out      = active & (state == ieg_pkg::BUS_ACK);
  end

  // ==========================================================
  // Checks
  AST_ONE_WAIT: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (active && waitrequest_out) |=> (!active || !waitrequest_out))
    else $error("Access waited more than one cycle");

  COV_ACCESS: cover property (
    @(posedge clock_in) disable iff (!rst_n_in)
    accept_out ##1 active ##1 accept_out);

endmodule : ieg_avs

// >>> rtl/ieg_top.sv
// Interrupt enable gating: two enable registers over Avalon-MM
// and the gating of ten pending sources toward the CPU.
// Assumes pending flags and the bus run on clock_in; no crossing.
//
// Contract
// - Global enable clear masks every source
// - Global enable set defers to each enable
// - Low bit 6 enables counter array
// - Low bit 5 enables timer 2 overflow
// - Low bit 4 enables serial port
// - Low bit 3 enables timer 1 overflow
// - Low bit 2 enables external interrupt 1
// - Low bit 1 enables timer 0 overflow
// - Low bit 0 enables external interrupt 0
// - High bit 2 enables timer overrun
// - High bit 1 enables analog converter
// - High bit 0 enables CAN controller
// - High bits 7..3 reserved, never written ones
// - Low register resets zero, bit writable
// - High implemented bits reset zero, bit writable
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
module ieg_top (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic [9:0]  src_pending_in,
  output logic      [9:0]  irq_request_out
);

  // ==========================================================
  // Bus front end
  ieg_pkg::ieg_bus_req_t bus;
  logic                  accept;

  always_comb begin
    bus.address    = avs_address_in;
    bus.read       = avs_read_in;
    bus.write      = avs_write_in;
    bus.writedata  = avs_writedata_in;
    bus.byteenable = avs_byteenable_in;
  end

  ieg_avs u_avs (
    .clock_in        (clock_in),
    .rst_n_in        (rst_n_in),
    .bus_in          (bus),
    .waitrequest_out (avs_waitrequest_out),
    .accept_out      (accept)
  );

  // ==========================================================
  // Single-bit update shared by both registers
  function automatic logic [7:0] apply_bit(
    input logic [7:0] value,
    input logic [2:0] index,
    input logic       level
  );
    logic [7:0] result;
    result        = value;
    result[index] = level;
    return result;
  endfunction : apply_bit

  // ==========================================================
  // Enable registers
  logic [7:0] interrupt_enable_low;
  logic [7:0] interrupt_enable_high;
  logic [7:0] next_interrupt_enable_low;
  logic [7:0] next_interrupt_enable_high;
  logic       write_take;
  logic       lane0;
  logic [2:0] bit_index;
  logic       bit_level;
  logic       bit_high_sel;

  always_comb begin
    write_take   = accept & bus.write;
    lane0        = bus.byteenable[0];
    bit_index    = bus.writedata[ieg_pkg::BITOP_IDX_MSB:
                                 ieg_pkg::BITOP_IDX_LSB];
    bit_level    = bus.writedata[ieg_pkg::BITOP_VAL_BIT];
    bit_high_sel = bus.writedata[ieg_pkg::BITOP_SEL_BIT];
    next_interrupt_enable_low  = interrupt_enable_low;
    next_interrupt_enable_high = interrupt_enable_high;
    if (write_take && lane0) begin
      case (bus.address)
        ieg_pkg::OFS_ENABLE_LOW: begin
          next_interrupt_enable_low = bus.writedata[7:0];
        end
        ieg_pkg::OFS_ENABLE_HIGH: begin
          // Reserved bits dropped so they never hold ones
          next_interrupt_enable_high = bus.writedata[7:0]
            & ieg_pkg::HIGH_IMPL_MASK;
        end
        ieg_pkg::OFS_BIT_ACCESS: begin
          if (bit_high_sel) begin
            next_interrupt_enable_high = apply_bit(
              interrupt_enable_high, bit_index, bit_level)
              & ieg_pkg::HIGH_IMPL_MASK;
          end else begin
            next_interrupt_enable_low = apply_bit(
              interrupt_enable_low, bit_index,
              bit_level);
          end
        end
        default: begin
          // Unmapped writes are ignored
          next_interrupt_enable_low  = interrupt_enable_low;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      interrupt_enable_low  <= ieg_pkg::LOW_RESET;
      interrupt_enable_high <= ieg_pkg::HIGH_RESET;
    end else begin
      interrupt_enable_low  <= next_interrupt_enable_low;
      interrupt_enable_high <= next_interrupt_enable_high;
    end
  end

  // ==========================================================
  // Named enable fields
  logic global_irq_enable;
  logic counter_array_irq_enable;
  logic timer2_overflow_irq_enable;
  logic serial_port_irq_enable;
  logic timer1_overflow_irq_enable;
  logic external1_irq_enable;
  logic timer0_overflow_irq_enable;
  logic external0_irq_enable;
  logic timer_overrun_irq_enable;
  logic converter_irq_enable;
  logic can_irq_enable;
  logic [ieg_pkg::NUM_SRC-1:0] source_enable;

  always_comb begin
    global_irq_enable          =
      interrupt_enable_low[ieg_pkg::GLOBAL_BIT];
    counter_array_irq_enable   =
      interrupt_enable_low[ieg_pkg::COUNTER_BIT];
    timer2_overflow_irq_enable =
      interrupt_enable_low[ieg_pkg::TIMER2_BIT];
    serial_port_irq_enable     =
      interrupt_enable_low[ieg_pkg::SERIAL_BIT];
    timer1_overflow_irq_enable =
      interrupt_enable_low[ieg_pkg::TIMER1_BIT];
    external1_irq_enable       =
      interrupt_enable_low[ieg_pkg::EXT1_BIT];
    timer0_overflow_irq_enable =
      interrupt_enable_low[ieg_pkg::TIMER0_BIT];
    external0_irq_enable       =
      interrupt_enable_low[ieg_pkg::EXT0_BIT];
    timer_overrun_irq_enable   =
      interrupt_enable_high[ieg_pkg::OVERRUN_BIT];
    converter_irq_enable       =
      interrupt_enable_high[ieg_pkg::CONVERT_BIT];
    can_irq_enable             =
      interrupt_enable_high[ieg_pkg::CAN_BIT];
    source_enable = {timer_overrun_irq_enable,
                     converter_irq_enable,
                     can_irq_enable,
                     counter_array_irq_enable,
                     timer2_overflow_irq_enable,
                     serial_port_irq_enable,
                     timer1_overflow_irq_enable,
                     external1_irq_enable,
                     timer0_overflow_irq_enable,
                     external0_irq_enable};
  end

  // ==========================================================
  // Gating toward the CPU
  ieg_gate u_gate (
    .clock_in     (clock_in),
    .rst_n_in     (rst_n_in),
    .global_en_in (global_irq_enable),
    .source_en_in (source_enable),
    .pending_in   (src_pending_in),
    .request_out  (irq_request_out)
  );

  // ==========================================================
  // Read data
  logic [31:0] next_readdata;

  always_comb begin
    next_readdata = ieg_pkg::READ_ZERO_WORD;
    case (bus.address)
      ieg_pkg::OFS_ENABLE_LOW: begin
        next_readdata[7:0] = interrupt_enable_low;
      end
      ieg_pkg::OFS_ENABLE_HIGH: begin
        // Reserved bits read as zero
        next_readdata[7:0] = interrupt_enable_high
                             & ieg_pkg::HIGH_IMPL_MASK;
      end
      ieg_pkg::OFS_STATUS: begin
        next_readdata[ieg_pkg::STAT_REQ_LSB +: ieg_pkg::NUM_SRC] =
          irq_request_out;
        next_readdata[ieg_pkg::STAT_PEND_LSB +: ieg_pkg::NUM_SRC] =
          src_pending_in;
      end
      default: begin
        next_readdata[7:0] = ieg_pkg::READ_ZERO_BYTE;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= ieg_pkg::READ_ZERO_WORD;
    end else begin
      avs_readdata_out <= next_readdata;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  AST_GLOBAL_MASK: assert property (
    !global_irq_enable |-> irq_request_out == '0)
    else $error("Request while global enable clear");

  AST_INDIVIDUAL: assert property (
    global_irq_enable |->
      irq_request_out == (src_pending_in & source_enable))
    else $error("Request differs from individual enables");

  AST_COUNTER: assert property (
    global_irq_enable && src_pending_in[6] |->
      irq_request_out[6] == interrupt_enable_low[6])
    else $error("Counter array gating wrong");

  AST_TIMER2: assert property (
    global_irq_enable && src_pending_in[5] |->
      irq_request_out[5] == interrupt_enable_low[5])
    else $error("Timer 2 gating wrong");

  AST_SERIAL: assert property (
    global_irq_enable && src_pending_in[4] |->
      irq_request_out[4] == interrupt_enable_low[4])
    else $error("Serial port gating wrong");

  AST_TIMER1: assert property (
    global_irq_enable && src_pending_in[3] |->
      irq_request_out[3] == interrupt_enable_low[3])
    else $error("Timer 1 gating wrong");

  AST_EXT1: assert property (
    global_irq_enable && src_pending_in[2] |->
      irq_request_out[2] == interrupt_enable_low[2])
    else $error("External 1 gating wrong");

  AST_TIMER0: assert property (
    global_irq_enable && src_pending_in[1] |->
      irq_request_out[1] == interrupt_enable_low[1])
    else $error("Timer 0 gating wrong");

  AST_EXT0: assert property (
    global_irq_enable && src_pending_in[0] |->
      irq_request_out[0] == interrupt_enable_low[0])
    else $error("External 0 gating wrong");

  AST_OVERRUN: assert property (
    global_irq_enable && src_pending_in[9] |->
      irq_request_out[9] == interrupt_enable_high[2])
    else $error("Timer overrun gating wrong");

  AST_CONVERT: assert property (
    global_irq_enable && src_pending_in[8] |->
      irq_request_out[8] == interrupt_enable_high[1])
    else $error("Converter gating wrong");

  AST_CAN: assert property (
    global_irq_enable && src_pending_in[7] |->
      irq_request_out[7] == interrupt_enable_high[0])
    else $error("CAN gating wrong");

  AST_RESERVED: assert property (
    interrupt_enable_high[7:3] == 5'h00)
    else $error("Reserved high bits hold a one");

  AST_LOW_RESET: assert property (
    $past(!rst_n_in) |-> interrupt_enable_low == 8'h00)
    else $error("Low register not zero after reset");

  AST_HIGH_RESET: assert property (
    $past(!rst_n_in) |-> interrupt_enable_high[2:0] == 3'h0)
    else $error("High register not zero after reset");

  AST_BIT_WRITE: assert property (
    write_take && lane0 && !bit_high_sel &&
    bus.address == ieg_pkg::OFS_BIT_ACCESS |=>
      interrupt_enable_low[$past(bit_index)] == $past(bit_level))
    else $error("Bit access write not applied");

  AST_READ_LOW: assert property (
    accept && bus.read &&
    bus.address == ieg_pkg::OFS_ENABLE_LOW |->
      avs_readdata_out == {24'h00_0000, interrupt_enable_low})
    else $error("Low register read data wrong");

  COV_GLOBAL_ON: cover property (
    !global_irq_enable ##1 global_irq_enable ##1 |irq_request_out);

  COV_BIT_HIGH: cover property (
    write_take && bus.address == ieg_pkg::OFS_BIT_ACCESS &&
    bit_high_sel);

  COV_READ_STATUS: cover property (
    accept && bus.read && bus.address == ieg_pkg::OFS_STATUS);

endmodule : ieg_top

// >>> verif/ieg_src_model.sv
// Far-side model: source flag logic and the CPU's request sampling.
// Assumes the bench sets the flag pattern; all on clock_in.
`timescale 1ns/1ps
module ieg_src_model (
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic [9:0] pattern_in,
  input  wire logic [9:0] irq_request_in,
  output logic      [9:0] pending_out,
  output logic      [15:0] req_cycles_out
);
  // ==========================================================
  // Flags are registered, as real source logic would be
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pending_out    <= 10'h000;
      req_cycles_out <= 16'h0000;
    end else begin
      pending_out <= pattern_in;
      // CPU side only notes that some request stood this cycle
      if (|irq_request_in) begin
        req_cycles_out <= req_cycles_out + 16'h0001;
      end
    end
  end
endmodule : ieg_src_model

// >>> verif/ieg_top_bench.sv
// Self-checking bench: register accesses over Avalon-MM and gating.
// Assumes one wait cycle per access but waits for waitrequest anyway.
`timescale 1ns/1ps
module ieg_top_bench;
  logic        clock_in;
  logic        rst_n_in;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [9:0]  pending;
  logic [9:0]  irq;
  logic [9:0]  pattern;
  logic [15:0] req_cycles;
  logic [31:0] rd;
  int          err_total;
  int          n_compared;

  ieg_top DUT (
    .clock_in            (clock_in),
    .rst_n_in            (rst_n_in),
    .avs_address_in      (address),
    .avs_read_in         (read),
    .avs_write_in        (write),
    .avs_writedata_in    (writedata),
    .avs_byteenable_in   (byteenable),
    .avs_readdata_out    (readdata),
    .avs_waitrequest_out (waitrequest),
    .src_pending_in      (pending),
    .irq_request_out     (irq)
  );

  ieg_src_model PARTNER (
    .clock_in       (clock_in),
    .rst_n_in       (rst_n_in),
    .pattern_in     (pattern),
    .irq_request_in (irq),
    .pending_out    (pending),
    .req_cycles_out (req_cycles)
  );

  // ==========================================================
  // Clock, 100 ns period
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  // ==========================================================
  // Comparison and closing
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // Bus master: hold until waitrequest seen low at a rising edge
  task automatic bus_cycle(input logic is_wr, input logic [7:0] addr,
                           input logic [31:0] data,
                           input logic [3:0] be);
    @(posedge clock_in);
    address    <= addr;
    writedata  <= data;
    byteenable <= be;
    read       <= !is_wr;
    write      <= is_wr;
    // Only the watchdog ends a wait that never finishes
    do begin
      @(posedge clock_in);
    end while (waitrequest !== 1'b0);
    // Taking edge: read data still shows its pre-edge value here
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus_cycle

  task automatic wr(input logic [7:0] addr, input logic [7:0] data,
                    input logic [3:0] be = 4'h1);
    bus_cycle(1'b1, addr, {24'h00_0000, data}, be);
  endtask : wr

  task automatic rd8(input logic [7:0] addr, input logic [7:0] mask,
                     input logic [7:0] exp, input string name);
    bus_cycle(1'b0, addr, 32'h0000_0000, 4'h1);
    check(name, {rd[31:8], rd[7:0] & mask}, {24'h00_0000, exp});
  endtask : rd8

  // Let enable and flag updates land before looking at requests
  task automatic settle;
    repeat (2) @(posedge clock_in);
    @(negedge clock_in);
  endtask : settle

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] lo;
    logic [7:0] hi;
    rst_n_in   = 1'b0;
    address    = 8'h00;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = 32'h0000_0000;
    byteenable = 4'h0;
    pattern    = 10'h000;
    err_total  = 0;
    n_compared = 0;
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rd8(ieg_pkg::OFS_ENABLE_LOW, 8'hff, 8'h00, "low reset");
    // Reserved bits may read anything
    rd8(ieg_pkg::OFS_ENABLE_HIGH, 8'h07, 8'h00, "high reset");
    pattern <= 10'h3ff;
    settle();
    check("irq after reset", {22'h0, irq}, 32'h0000_0000);
    // One source enabled at a time, every flag pending, then every flag but its own
    for (int i = 0; i < 10; i++) begin
      lo = (i < 7) ? (8'h80 | (8'h01 << i)) : 8'h80;
      hi = (i < 7) ? 8'h00 : (8'h01 << (i - 7));
      wr(ieg_pkg::OFS_ENABLE_LOW, lo);
      wr(ieg_pkg::OFS_ENABLE_HIGH, hi);
      pattern <= 10'h3ff;
      settle();
      check("one source", {22'h0, irq}, 32'h1 << i);
      case (i)
        0: check("ext0 bit", {31'h0, irq[0]}, 32'h1);
        1: check("timer0 bit", {31'h0, irq[1]}, 32'h1);
        2: check("ext1 bit", {31'h0, irq[2]}, 32'h1);
        3: check("timer1 bit", {31'h0, irq[3]}, 32'h1);
        4: check("serial bit", {31'h0, irq[4]}, 32'h1);
        5: check("timer2 bit", {31'h0, irq[5]}, 32'h1);
        6: check("counter bit", {31'h0, irq[6]}, 32'h1);
        7: check("can bit", {31'h0, irq[7]}, 32'h1);
        8: check("convert bit", {31'h0, irq[8]}, 32'h1);
        default: check("overrun bit", {31'h0, irq[9]}, 32'h1);
      endcase
      pattern <= ~(10'h001 << i);
      settle();
      check("enabled, not pending", {22'h0, irq}, 32'h0);
    end
    wr(ieg_pkg::OFS_ENABLE_LOW, 8'h7f);
    wr(ieg_pkg::OFS_ENABLE_HIGH, 8'h07);
    pattern <= 10'h3ff;
    settle();
    check("global off", {22'h0, irq}, 32'h0);
    wr(ieg_pkg::OFS_ENABLE_LOW, 8'hff);
    pattern <= 10'h2a5;
    settle();
    check("mixed flags", {22'h0, irq}, 32'h0000_02a5);
    bus_cycle(1'b0, ieg_pkg::OFS_STATUS, 32'h0, 4'h1);
    check("status", rd, 32'h02a5_02a5);
    check("cpu saw requests", {31'h0, req_cycles != 16'h0}, 32'h1);
    // Refused writes leave the low register alone
    wr(8'h20, 8'h00);
    wr(ieg_pkg::OFS_ENABLE_LOW, 8'h00, 4'h0);
    rd8(8'h20, 8'hff, 8'h00, "unmapped read");
    rd8(ieg_pkg::OFS_ENABLE_LOW, 8'hff, 8'hff, "refused writes");
    // Single-bit access: clear bit 7, set high bit 2, clear high bit 0
    wr(ieg_pkg::OFS_BIT_ACCESS, 8'h07);
    wr(ieg_pkg::OFS_BIT_ACCESS, 8'h1a);
    wr(ieg_pkg::OFS_BIT_ACCESS, 8'h10);
    rd8(ieg_pkg::OFS_ENABLE_LOW, 8'hff, 8'h7f, "bit clear low");
    rd8(ieg_pkg::OFS_ENABLE_HIGH, 8'h07, 8'h06, "bit ops high");
    settle();
    check("global cleared by bit", {22'h0, irq}, 32'h0);
    wr(ieg_pkg::OFS_BIT_ACCESS, 8'h0f);
    settle();
    check("global set by bit", {22'h0, irq}, 32'h0000_0225);
    // Reset in mid-run clears both registers
    @(posedge clock_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rd8(ieg_pkg::OFS_ENABLE_LOW, 8'hff, 8'h00, "low re-reset");
    rd8(ieg_pkg::OFS_ENABLE_HIGH, 8'h07, 8'h00, "high re-reset");
    wrap_up();
  end

  // Whole sequence needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge clock_in);
    err_total++;
    wrap_up();
  end
endmodule : ieg_top_bench
